/* rtl/cas_core.sv */
// Purpose: execution datapath for a small instruction subset of an 8-bit core
// Assumes: register file is outside; it answers file_addr_q with file_rdata by q3
// Notes: one instruction is issued at q1 and committed at the end of q4
// How it works
// - invert the addressed file byte, update zero, send to accumulator on 0 or file on 1.
// - clear the addressed file byte and always set the zero flag.
// - subtract one from the file byte, update zero, send per destination select.
// - clear the accumulator and set the zero flag.
// - rotate the file byte up through carry, old carry into bit 0, bit 7 to carry.
// - rotate the file byte down through carry, old carry into bit 7, bit 0 to carry.
// - accumulator gets literal minus accumulator, carry and half carry mean no borrow.
// - power-down clears the power-down flag and sets the time-out flag (both active low).
// - power-down zeroes watchdog counter and prescaler, then halts with clock stopped.
// - each instruction cycle spans four oscillator periods.
`timescale 1ns/10ps
module cas_core
   import cas_pkg::*;
#(
   parameter int WDT_W = WDT_W_DEF,
   parameter int PRESCALE_W = PRESCALE_W_DEF
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic op_valid,
   input wire cas_op_t op_code,
   input wire logic dest_sel,
   input wire logic [ADDR_W-1:0] file_addr,
   input wire logic [7:0] literal,
   input wire logic [7:0] file_rdata,
   input wire logic wake_pin,
   output logic [ADDR_W-1:0] file_addr_q,
   output logic [7:0] file_wdata_q,
   output logic file_we_q,
   output logic [7:0] accum_q,
   output logic carry_q,
   output logic half_byte_borrow_q,
   output logic zero_q,
   output logic timeout_status_q,
   output logic power_down_flag_q,
   output logic [WDT_W-1:0] watchdog_counter_q,
   output logic [PRESCALE_W-1:0] prescaler_q,
   output logic osc_stopped_q,
   output logic cycle_done_q,
   output cas_phase_t phase_q
);
   if (WDT_W < 1 || WDT_W > 32 || PRESCALE_W < 1 || PRESCALE_W > 32) begin : g_bad
      $error("cas_core: counter widths must lie in 1..32");
   end

   cas_op_t op_q;
   logic dest_q;
   logic [7:0] lit_q;
   logic [7:0] operand_q;
   logic ex_q;
   logic wake_s1_q;
   logic wake_s2_q;
   logic run;
   logic commit;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_wr_file;
   logic alu_wr_accum;
   logic alu_upd_c;
   logic alu_upd_dc;
   logic alu_upd_z;
   logic alu_sleep;

   // oscillator stopped means nothing but the wake synchroniser advances
   assign run = clk_en && !osc_stopped_q;
   assign commit = run && ex_q && (phase_q == PH_Q4);

   cas_alu u_alu (
      .op(op_q),
      .dest_file(dest_q),
      .operand(operand_q),
      .accum(accum_q),
      .literal(lit_q),
      .carry_in(carry_q),
      .result(alu_res),
      .carry_out(alu_c),
      .dc_out(alu_dc),
      .wr_file(alu_wr_file),
      .wr_accum(alu_wr_accum),
      .upd_c(alu_upd_c),
      .upd_dc(alu_upd_dc),
      .upd_z(alu_upd_z),
      .go_sleep(alu_sleep)
   );

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else if (clk_en) begin
         wake_s1_q <= wake_pin;
         wake_s2_q <= wake_s1_q;
      end
   end

   // four oscillator periods per instruction
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         phase_q <= PH_Q1;
      end else if (run) begin
         case (phase_q)
            PH_Q1: phase_q <= PH_Q2;
            PH_Q2: phase_q <= PH_Q3;
            PH_Q3: phase_q <= PH_Q4;
            PH_Q4: phase_q <= PH_Q1;
            default: phase_q <= PH_Q1;
         endcase
      end
   end

   // issue at q1, operand fetch at q3
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         op_q <= OP_ZERO_ACCUM;
         dest_q <= DEST_ACCUM;
         lit_q <= ZERO_BYTE;
         file_addr_q <= '0;
         operand_q <= ZERO_BYTE;
         ex_q <= 1'b0;
      end else if (run) begin
         if (phase_q == PH_Q1) begin
            ex_q <= op_valid;
            if (op_valid) begin
               op_q <= op_code;
               dest_q <= dest_sel;
               lit_q <= literal;
               file_addr_q <= file_addr;
            end
         end
         if (phase_q == PH_Q3) begin
            operand_q <= file_rdata;
         end
         if (commit) begin
            ex_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         file_we_q <= 1'b0;
         file_wdata_q <= ZERO_BYTE;
         cycle_done_q <= 1'b0;
      end else if (clk_en) begin
         file_we_q <= commit && alu_wr_file;
         cycle_done_q <= commit;
         if (commit && alu_wr_file) begin
            file_wdata_q <= alu_res;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         accum_q <= ACCUM_RST;
         carry_q <= 1'b0;
         half_byte_borrow_q <= 1'b0;
         zero_q <= 1'b0;
      end else if (commit) begin
         if (alu_wr_accum) begin
            accum_q <= alu_res;
         end
         if (alu_upd_c) begin
            carry_q <= alu_c;
         end
         if (alu_upd_dc) begin
            half_byte_borrow_q <= alu_dc;
         end
         if (alu_upd_z) begin
            zero_q <= is_zero(alu_res);
         end
      end
   end

   // watchdog: prescaler counts instruction cycles; halted while asleep
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         watchdog_counter_q <= '0;
         prescaler_q <= '0;
      end else if (commit && alu_sleep) begin
         watchdog_counter_q <= '0;
         prescaler_q <= '0;
      end else if (run && phase_q == PH_Q4) begin
         prescaler_q <= prescaler_q + 1'b1;
         if (&prescaler_q) begin
            watchdog_counter_q <= watchdog_counter_q + 1'b1;
         end
      end
   end

   // status bits are active low: power-down clears pd, sets to
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         timeout_status_q <= TIMEOUT_RST;
         power_down_flag_q <= POWER_DOWN_RST;
      end else if (commit && alu_sleep) begin
         power_down_flag_q <= 1'b0;
         timeout_status_q <= 1'b1;
      end
   end

   // wake only from a synchronised level; sleep wins if both land together
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         osc_stopped_q <= 1'b0;
      end else if (clk_en) begin
         if (commit && alu_sleep) begin
            osc_stopped_q <= 1'b1;
         end else if (osc_stopped_q && wake_s2_q) begin
            osc_stopped_q <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   sequence s_commit_op(cas_op_t o);
      commit && op_q == o;
   endsequence

   sequence s_run_q1_q3;
      (run && phase_q == PH_Q1) ##1 (run && phase_q == PH_Q2) ##1 (run && phase_q == PH_Q3);
   endsequence

   chk_invert_value: assert property (s_commit_op(OP_INVERT_FILE) |=>
      (dest_q ? (file_we_q && file_wdata_q == ~$past(operand_q)) : (accum_q == ~$past(operand_q))))
      else $error("invert result wrong");
   chk_zero_file: assert property (s_commit_op(OP_ZERO_FILE) |=>
      file_we_q && file_wdata_q == ZERO_BYTE && zero_q)
      else $error("clear file wrong");
   chk_minus_one: assert property (s_commit_op(OP_MINUS_ONE_FILE) ##0 !dest_q |=>
      accum_q == $past(operand_q) - ONE_BYTE && !file_we_q)
      else $error("decrement wrong");
   chk_zero_accum: assert property (s_commit_op(OP_ZERO_ACCUM) |=>
      accum_q == ZERO_BYTE && zero_q && !file_we_q)
      else $error("clear accumulator wrong");
   chk_rotate_up: assert property (s_commit_op(OP_ROTATE_UP) |=>
      carry_q == $past(operand_q[MSB_POS]))
      else $error("rotate up carry wrong");
   chk_rotate_down: assert property (s_commit_op(OP_ROTATE_DOWN) ##0 !dest_q |=>
      accum_q == {$past(carry_q), $past(operand_q[MSB_POS:1])} && carry_q == $past(operand_q[0]))
      else $error("rotate down wrong");
   chk_sub_flags: assert property (s_commit_op(OP_LITERAL_MINUS_ACCUM) |=>
      carry_q == ($past(accum_q) <= $past(lit_q)) && accum_q == $past(lit_q) - $past(accum_q) &&
      half_byte_borrow_q == ($past(accum_q[NIBBLE_MSB:0]) <= $past(lit_q[NIBBLE_MSB:0])))
      else $error("literal subtract wrong");
   chk_sleep_status: assert property (s_commit_op(OP_SLEEP) |=>
      !power_down_flag_q && timeout_status_q)
      else $error("sleep status wrong");
   chk_sleep_halt: assert property (s_commit_op(OP_SLEEP) |=>
      watchdog_counter_q == '0 && prescaler_q == '0 && osc_stopped_q && phase_q == PH_Q1)
      else $error("sleep halt wrong");
   chk_cycle_len: assert property (s_run_q1_q3 |=> phase_q == PH_Q4)
      else $error("instruction cycle not four periods");
   chk_zero_flag: assert property (commit && alu_upd_z |=> zero_q == is_zero(accum_q) ||
      (file_we_q && zero_q == is_zero(file_wdata_q)))
      else $error("zero flag wrong");
endmodule

/* rtl/cas_pkg.sv */
// Purpose: shared constants and types for the instruction subset datapath
// Assumes: mclk is the oscillator time base itself
// Notes: one instruction cycle is four mclk periods, phases q1..q4
package cas_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int WDT_W_DEF = 8;
   localparam int PRESCALE_W_DEF = 7;

   // timing: oscillator period and periods per instruction cycle
   localparam int OSC_PERIOD_NS = 100;
   localparam int CYCLE_OSC_PERIODS = 4;
   localparam int INSTR_PERIOD_NS = CYCLE_OSC_PERIODS * OSC_PERIOD_NS;
   localparam int INSTR_PERIOD_TICKS = INSTR_PERIOD_NS / OSC_PERIOD_NS;

   // reset values and byte constants
   localparam logic [7:0] ACCUM_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] ONE_BYTE = 8'h01;
   localparam logic TIMEOUT_RST = 1'b1;
   localparam logic POWER_DOWN_RST = 1'b1;
   localparam logic DEST_ACCUM = 1'b0;

   // bit positions
   localparam int MSB_POS = 7;
   localparam int NIBBLE_MSB = 3;

   typedef enum logic [2:0] {
      OP_INVERT_FILE,
      OP_ZERO_FILE,
      OP_MINUS_ONE_FILE,
      OP_ZERO_ACCUM,
      OP_ROTATE_UP,
      OP_ROTATE_DOWN,
      OP_LITERAL_MINUS_ACCUM,
      OP_SLEEP
   } cas_op_t;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cas_phase_t;

   function automatic logic is_zero(input logic [7:0] v);
      return v == ZERO_BYTE;
   endfunction
endpackage

/* rtl/cas_alu.sv */
// Purpose: combinational result and flag logic for the instruction subset
// Assumes: operands are stable while the core commits
// Notes: upd_* tell the core which flags the operation touches
`timescale 1ns/10ps
module cas_alu
   import cas_pkg::*;
(
   input wire cas_op_t op,
   input wire logic dest_file,
   input wire logic [7:0] operand,
   input wire logic [7:0] accum,
   input wire logic [7:0] literal,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out,
   output logic dc_out,
   output logic wr_file,
   output logic wr_accum,
   output logic upd_c,
   output logic upd_dc,
   output logic upd_z,
   output logic go_sleep
);
   logic sel_file;
   assign sel_file = (dest_file != DEST_ACCUM);

   always_comb begin
      result = ZERO_BYTE;
      carry_out = carry_in;
      dc_out = 1'b0;
      wr_file = 1'b0;
      wr_accum = 1'b0;
      upd_c = 1'b0;
      upd_dc = 1'b0;
      upd_z = 1'b0;
      go_sleep = 1'b0;
      case (op)
         OP_INVERT_FILE: begin
            result = ~operand;
            wr_file = sel_file;
            wr_accum = !sel_file;
            upd_z = 1'b1;
         end
         OP_ZERO_FILE: begin
            result = ZERO_BYTE;
            wr_file = 1'b1;
            upd_z = 1'b1;
         end
         OP_MINUS_ONE_FILE: begin
            result = operand - ONE_BYTE;
            wr_file = sel_file;
            wr_accum = !sel_file;
            upd_z = 1'b1;
         end
         OP_ZERO_ACCUM: begin
            result = ZERO_BYTE;
            wr_accum = 1'b1;
            upd_z = 1'b1;
         end
         OP_ROTATE_UP: begin
            result = {operand[MSB_POS-1:0], carry_in};
            carry_out = operand[MSB_POS];
            wr_file = sel_file;
            wr_accum = !sel_file;
            upd_c = 1'b1;
         end
         OP_ROTATE_DOWN: begin
            result = {carry_in, operand[MSB_POS:1]};
            carry_out = operand[0];
            wr_file = sel_file;
            wr_accum = !sel_file;
            upd_c = 1'b1;
         end
         OP_LITERAL_MINUS_ACCUM: begin
            result = literal - accum;
            carry_out = (accum <= literal);
            dc_out = (accum[NIBBLE_MSB:0] <= literal[NIBBLE_MSB:0]);
            wr_accum = 1'b1;
            upd_c = 1'b1;
            upd_dc = 1'b1;
            upd_z = 1'b1;
         end
         OP_SLEEP: begin
            go_sleep = 1'b1;
         end
         default: begin
            result = ZERO_BYTE;
         end
      endcase
   end
endmodule

/* sim/cas_core_tb.sv */
// Purpose: self-checking bench for the instruction subset datapath
// Assumes: bench plays the register file and holds read data per instruction
// Notes: a reference model predicts every commit, compared at cycle_done_q
`timescale 1ns/10ps
module cas_core_tb;
   import cas_pkg::*;
   typedef struct {
      logic [7:0] acc;
      logic c;
      logic dc;
      logic z;
      logic pd;
      logic we;
      logic fop;
      logic slp;
      logic [7:0] wd;
      logic [6:0] a;
      time tt;
   } cas_exp_t;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   logic op_valid = 1'b0;
   cas_op_t op_code = OP_INVERT_FILE;
   logic dest_sel = 1'b0;
   logic [ADDR_W-1:0] file_addr = 7'h00;
   logic [7:0] literal = 8'h00;
   logic [7:0] file_rdata = 8'h00;
   logic wake_pin = 1'b0;
   logic [ADDR_W-1:0] file_addr_q;
   logic [7:0] file_wdata_q;
   logic file_we_q;
   logic [7:0] accum_q;
   logic carry_q;
   logic half_byte_borrow_q;
   logic zero_q;
   logic timeout_status_q;
   logic power_down_flag_q;
   logic [WDT_W_DEF-1:0] watchdog_counter_q;
   logic [PRESCALE_W_DEF-1:0] prescaler_q;
   logic osc_stopped_q;
   logic cycle_done_q;
   cas_phase_t phase_q;
   logic [7:0] m_acc = 8'h00;
   logic m_c = 1'b0;
   logic m_dc = 1'b0;
   logic m_z = 1'b0;
   logic m_pd = 1'b1;
   logic tchk = 1'b1;
   cas_exp_t q[$];
   cas_exp_t mon_e;
   time mon_t;
   time base_t;
   int mon_n;
   int num_errors = 0;
   int n_compared = 0;
   int i;
   int n;
   cas_op_t d_op[14] = '{OP_INVERT_FILE, OP_INVERT_FILE, OP_ZERO_FILE, OP_MINUS_ONE_FILE,
      OP_MINUS_ONE_FILE, OP_ZERO_ACCUM, OP_ROTATE_UP, OP_ROTATE_UP, OP_ROTATE_DOWN,
      OP_ROTATE_DOWN, OP_LITERAL_MINUS_ACCUM, OP_LITERAL_MINUS_ACCUM,
      OP_LITERAL_MINUS_ACCUM, OP_LITERAL_MINUS_ACCUM};
   logic [13:0] d_d = 14'h018a;
   logic [7:0] d_v[14] = '{8'hff, 8'h5a, 8'h33, 8'h00, 8'h01, 8'h00, 8'he6, 8'h00,
      8'h01, 8'h00, 8'h80, 8'h7f, 8'h7e, 8'h0f};

   cas_core u_dut (.mclk, .reset, .clk_en, .op_valid, .op_code, .dest_sel, .file_addr,
      .literal, .file_rdata, .wake_pin, .file_addr_q, .file_wdata_q, .file_we_q, .accum_q,
      .carry_q, .half_byte_borrow_q, .zero_q, .timeout_status_q, .power_down_flag_q,
      .watchdog_counter_q, .prescaler_q, .osc_stopped_q, .cycle_done_q, .phase_q);

   initial begin
      forever begin
         #(OSC_PERIOD_NS / 2) mclk = ~mclk;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // model first, then drive at the q1 edge; op_valid held into q2 must be ignored
   task automatic issue(input cas_op_t op, input logic d, input logic [7:0] fd,
                        input logic [7:0] k);
      cas_exp_t e;
      logic [7:0] r;
      int c;
      c = 0;
      e.a = 7'($urandom_range(127, 0));
      e.slp = (op == OP_SLEEP);
      e.fop = !(op inside {OP_ZERO_ACCUM, OP_LITERAL_MINUS_ACCUM, OP_SLEEP});
      case (op)
         OP_INVERT_FILE: r = ~fd;
         OP_MINUS_ONE_FILE: r = fd - 8'h01;
         OP_ROTATE_UP: r = {fd[6:0], m_c};
         OP_ROTATE_DOWN: r = {m_c, fd[7:1]};
         OP_LITERAL_MINUS_ACCUM: r = k - m_acc;
         default: r = 8'h00;
      endcase
      m_c = (op == OP_ROTATE_UP) ? fd[7] : (op == OP_ROTATE_DOWN) ? fd[0] :
            (op == OP_LITERAL_MINUS_ACCUM) ? (m_acc <= k) : m_c;
      if (op == OP_LITERAL_MINUS_ACCUM) begin
         m_dc = (m_acc[3:0] <= k[3:0]);
      end
      if (!(op inside {OP_ROTATE_UP, OP_ROTATE_DOWN, OP_SLEEP})) begin
         m_z = (r == 8'h00);
      end
      m_pd = e.slp ? 1'b0 : m_pd;
      e.we = e.fop && (d || op == OP_ZERO_FILE);
      if (!e.we && !e.slp) begin
         m_acc = r;
      end
      e.acc = m_acc;
      e.c = m_c;
      e.dc = m_dc;
      e.z = m_z;
      e.pd = m_pd;
      e.wd = r;
      do begin
         @(posedge mclk);
         #1;
         c++;
      end while (phase_q !== PH_Q4 && c < 40);
      @(posedge mclk);
      op_valid <= 1'b1;
      op_code <= op;
      dest_sel <= d;
      file_addr <= e.a;
      literal <= k;
      file_rdata <= fd;
      @(posedge mclk);
      e.tt = $time;
      q.push_back(e);
      op_code <= OP_ZERO_ACCUM;
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
   endtask

   always @(posedge mclk) begin
      mon_t = $time;
      #1;
      if (cycle_done_q === 1'b1 && q.size() == 0) begin
         chk(32'(1), 32'(0), "stray result");
      end else if (cycle_done_q === 1'b1) begin
         mon_e = q.pop_front();
         chk(32'(accum_q), 32'(mon_e.acc), "accum");
         chk(32'(carry_q), 32'(mon_e.c), "carry");
         chk(32'(half_byte_borrow_q), 32'(mon_e.dc), "half");
         chk(32'(zero_q), 32'(mon_e.z), "zero");
         chk(32'(file_we_q), 32'(mon_e.we), "we");
         if (mon_e.we) begin
            chk(32'(file_wdata_q), 32'(mon_e.wd), "wdata");
         end
         if (mon_e.fop) begin
            chk(32'(file_addr_q), 32'(mon_e.a), "addr");
         end
         chk(32'({timeout_status_q, power_down_flag_q}), 32'({1'b1, mon_e.pd}), "st");
         if (tchk) begin
            chk(32'(mon_t - mon_e.tt), 32'(INSTR_PERIOD_NS - OSC_PERIOD_NS), "span");
         end
         if (tchk && !mon_e.slp) begin
            mon_n = int'((mon_t - base_t) / INSTR_PERIOD_NS) + 1;
            chk(32'(prescaler_q), 32'(mon_n % 128), "presc");
            chk(32'(watchdog_counter_q), 32'(mon_n / 128 % 256), "wdog");
         end
         if (mon_e.slp) begin
            chk(32'({watchdog_counter_q, prescaler_q}), 32'(0), "clear");
            chk(32'({osc_stopped_q, phase_q}), 32'({1'b1, PH_Q1}), "stop");
            tchk = 1'b0;
         end
      end
   end

   initial begin
      #(5000 * OSC_PERIOD_NS);
      num_errors++;
      $display("CHECK FAILED t=%0t run timed out", $time);
      close_out();
   end

   initial begin
      void'($urandom(61751));
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      base_t = $time + INSTR_PERIOD_NS;
      #1;
      chk(32'({accum_q, carry_q, zero_q, timeout_status_q, power_down_flag_q}),
          32'({8'h00, 4'h3}), "reset");
      for (i = 0; i < 14; i++) begin
         issue(d_op[i], d_d[i], d_v[i], d_v[i]);
      end
      repeat (150) begin
         issue(cas_op_t'($urandom_range(6, 0)), 1'($urandom_range(1, 0)), 8'($urandom),
               8'($urandom));
      end
      issue(OP_SLEEP, 1'b0, 8'h00, 8'h00);
      // a halted core must ignore a standing request
      repeat (4) @(posedge mclk);
      op_valid <= 1'b1;
      repeat (12) @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      chk(32'({accum_q, osc_stopped_q}), 32'({m_acc, 1'b1}), "asleep");
      @(posedge mclk);
      wake_pin <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
      end while (osc_stopped_q !== 1'b0 && n < 10);
      chk(32'(osc_stopped_q), 32'(0), "wake");
      @(posedge mclk);
      wake_pin <= 1'b0;
      // freeze mid-instruction; result must still match once enable returns
      fork
         issue(OP_INVERT_FILE, 1'b0, 8'h0f, 8'h00);
         begin
            @(posedge op_valid);
            repeat (2) @(posedge mclk);
            clk_en <= 1'b0;
            repeat (5) @(posedge mclk);
            clk_en <= 1'b1;
         end
      join
      repeat (12) @(posedge mclk);
      #1;
      chk(32'(q.size()), 32'(0), "pending");
      close_out();
   end
endmodule
